/* rtl/psc_device.sv */
// configured-device end of the passive serial configuration port
// Operation
// (R1) data sampled on bit clock rising edge
// (R2) host sends bytes LSB first, file order
// (R3) init clock: oscillator, or user clock option
// (R4) oscillator mode runs init cycles unaided
// (R5) bit clock ignored after configuration
// (R6) user clock never touches data transfer
// (R7) host bit clock at most 125 MHz
// (R8) chain enable out low once loaded
// (R9) start receiving within one bit clock
// (R10) init only after shared complete released
// (R11) detected error pulls shared status low
// (R12) host restarts whole chain after error
// (R13) broadcast: enable tied low, chain unused
// (R14) host requests reconfig with request low
// (R15) host clocks until complete rises
// (R16) host gives two falling edges afterwards
// (R17) host halts and reports on status low
`timescale 1ns/10ps
module psc_device
  import psc_pkg::*;
#(
  parameter int CFG_BITS = 64,
  parameter logic [7:0] SYNC_BYTE = SYNC_BYTE_RESET,
  parameter int INIT_OSC_COUNT = INIT_OSC_CYC,
  parameter int INIT_USR_COUNT = INIT_USR_EDGES
) (
  input wire logic clock_in,
  input wire logic rst_in,
  psc_link_if.dev link,
  input wire logic use_user_clock_in,
  output logic user_mode_out,
  output logic config_error_out,
  output logic [7:0] config_byte_out,
  output logic config_byte_valid_out
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // bit order: 0 clk, 1 data, 2 enable_n, 3 request_n,
  // 4 status_n, 5 complete, 6 user clock
  localparam int NS = 7;
  // stages start at the pins' levels during reset: request high, the rest
  // low, so no false request or edge shows once reset is released
  localparam logic [NS-1:0] PIN_IDLE = 7'h08;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] s1_reg;
  logic [NS-1:0] s2_reg;
  logic [NS-1:0] s3_reg;
  logic [NS-1:0] stable_reg;
  logic [NS-1:0] stable_next;
  logic [NS-1:0] settled;

  assign pin_raw = {link.user_startup_clock, link.config_complete,
    link.config_status_n, link.config_request_n, link.chip_enable_in_n,
    link.serial_config_data, link.config_bit_clock};
  // a change counts only once stages two and three agree
  assign settled = ~(s2_reg ^ s3_reg);
  assign stable_next = (settled & s3_reg) | (~settled & stable_reg);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s1_reg <= PIN_IDLE;
      s2_reg <= PIN_IDLE;
      s3_reg <= PIN_IDLE;
      stable_reg <= PIN_IDLE;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stable_reg <= stable_next;
    end
  end

  logic bclk_rise;
  logic uclk_rise;
  logic data_lvl;
  logic ce_n_lvl;
  logic req_n_lvl;
  logic status_lvl;
  logic complete_lvl;

  assign bclk_rise = stable_next[0] & ~stable_reg[0];
  assign uclk_rise = stable_next[6] & ~stable_reg[6];
  assign data_lvl = stable_next[1];
  assign ce_n_lvl = stable_reg[2];
  assign req_n_lvl = stable_reg[3];
  assign status_lvl = stable_reg[4];
  assign complete_lvl = stable_reg[5];

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  psc_dev_state_e state_reg;
  psc_dev_state_e state_next;
  logic [31:0] bit_cnt_reg;
  logic [31:0] bit_cnt_next;
  logic [31:0] init_cnt_reg;
  logic [31:0] init_cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic first_byte_reg;
  logic first_byte_next;
  logic own_err_reg;
  logic own_err_next;

  logic take_bit;
  logic byte_full;
  logic sync_bad;
  logic last_bit;
  logic init_tick;
  logic init_end;
  logic halt_seen;

  assign take_bit = (state_reg == D_RECV) && bclk_rise; // [R1] [R5]
  assign shift_next = take_bit ? {data_lvl, shift_reg[7:1]} // [R2]
    : shift_reg;
  assign byte_full = take_bit && (bit_cnt_reg[2:0] == 3'h7);
  assign sync_bad = byte_full && first_byte_reg
    && (shift_next != SYNC_BYTE);
  assign last_bit = take_bit && (bit_cnt_reg == 32'(CFG_BITS - 1));
  // user clock is only looked at while initialising
  assign init_tick = use_user_clock_in ? uclk_rise : 1'b1; // [R3] [R6]
  assign init_end = use_user_clock_in
    ? (init_cnt_reg == 32'(INIT_USR_COUNT - 1))
    : (init_cnt_reg == 32'(INIT_OSC_COUNT - 1)); // [R4]
  // shared status low from any device halts this one too, until it starts initialising
  assign halt_seen = ~status_lvl;

  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    init_cnt_next = init_cnt_reg;
    first_byte_next = first_byte_reg;
    own_err_next = own_err_reg;
    if (take_bit) begin
      bit_cnt_next = bit_cnt_reg + 32'h1;
    end
    if (byte_full) begin
      first_byte_next = 1'b0;
    end
    unique case (state_reg)
      D_RESET: begin
        bit_cnt_next = '0;
        init_cnt_next = '0;
        first_byte_next = 1'b1;
        own_err_next = 1'b0;
        if (req_n_lvl) begin
          state_next = D_WAIT_ST;
        end
      end
      D_WAIT_ST: begin
        if (status_lvl) begin
          state_next = D_WAIT_CE;
        end
      end
      D_WAIT_CE: begin
        // enable seen in a few fast cycles, far under one bit period
        if (halt_seen) begin
          state_next = D_ERR;
        end else if (!ce_n_lvl) begin
          state_next = D_RECV; // [R9] [R13]
        end
      end
      D_RECV: begin
        if (halt_seen) begin
          state_next = D_ERR;
        end else if (sync_bad) begin
          own_err_next = 1'b1; // [R11]
          state_next = D_ERR;
        end else if (last_bit) begin
          state_next = D_DONE_WAIT;
        end
      end
      D_DONE_WAIT: begin
        if (halt_seen) begin
          state_next = D_ERR;
        end else if (complete_lvl) begin
          state_next = D_INIT; // [R10]
        end
      end
      D_INIT: begin
        if (init_tick) begin
          init_cnt_next = init_cnt_reg + 32'h1;
          if (init_end) begin
            state_next = D_USER;
          end
        end
      end
      D_USER: begin
        state_next = D_USER; // [R5]
      end
      D_ERR: begin
        state_next = D_ERR;
      end
    endcase
    // request low restarts from any state
    if (!req_n_lvl) begin
      state_next = D_RESET;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= D_RESET;
      bit_cnt_reg <= '0;
      init_cnt_reg <= '0;
      shift_reg <= '0;
      first_byte_reg <= 1'b1;
      own_err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      init_cnt_reg <= init_cnt_next;
      shift_reg <= shift_next;
      first_byte_reg <= first_byte_next;
      own_err_reg <= own_err_next;
    end
  end

  // ----------------------------------------------------------------
  // pins and user outputs
  // ----------------------------------------------------------------
  logic ceo_n_reg;
  logic status_low_reg;
  logic complete_low_reg;
  logic user_reg;
  logic err_reg;
  logic [7:0] byte_reg;
  logic byte_valid_reg;
  logic loaded;

  assign loaded = (state_next == D_DONE_WAIT) || (state_next == D_INIT)
    || (state_next == D_USER);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ceo_n_reg <= 1'b1;
      status_low_reg <= 1'b1;
      complete_low_reg <= 1'b1;
      user_reg <= 1'b0;
      err_reg <= 1'b0;
      byte_reg <= '0;
      byte_valid_reg <= 1'b0;
    end else begin
      ceo_n_reg <= ~loaded; // [R8]
      status_low_reg <= (state_next == D_RESET) || own_err_next; // [R11]
      complete_low_reg <= ~loaded; // [R10]
      user_reg <= (state_next == D_USER);
      err_reg <= (state_next == D_ERR);
      byte_valid_reg <= byte_full;
      if (byte_full) begin
        byte_reg <= shift_next;
      end
    end
  end

  assign link.chain_enable_out_n = ceo_n_reg;
  assign link.status_drv = 1'b0;
  assign link.status_oe = status_low_reg;
  assign link.complete_drv = 1'b0;
  assign link.complete_oe = complete_low_reg;
  assign user_mode_out = user_reg;
  assign config_error_out = err_reg;
  assign config_byte_out = byte_reg;
  assign config_byte_valid_out = byte_valid_reg;

endmodule : psc_device

/* common/psc_pkg.sv */
// shared constants and types of the passive serial configuration port
package psc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int T_CFG_NS = 2000;
  localparam int T_ST2CK_NS = 2000;
  localparam int T_BIT_PERIOD_NS = 80;
  localparam int T_BIT_MIN_NS = 8;
  localparam int T_INIT_OSC_NS = 55000;
  localparam int INIT_USR_EDGES = 8532;
  localparam int POST_FALL_EDGES = 2;
  localparam logic [15:0] T_CFG_CYC =
    16'((T_CFG_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] T_ST2CK_CYC =
    16'((T_ST2CK_NS * CLK_MHZ + 999) / 1000);
  localparam int HALF_MIN_CYC = (T_BIT_MIN_NS * CLK_MHZ + 1999) / 2000;
  localparam int HALF_NOM_CYC = T_BIT_PERIOD_NS * CLK_MHZ / 2000;
  localparam logic [15:0] BIT_HALF_CYC = 16'((HALF_NOM_CYC > HALF_MIN_CYC)
    ? HALF_NOM_CYC : HALF_MIN_CYC);
  localparam int INIT_OSC_CYC = T_INIT_OSC_NS * CLK_MHZ / 1000;

  // ----------------------------------------------------------------
  // host register map and fields
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_DATA = 5'h08;
  localparam logic [4:0] REG_IRQ_STATUS = 5'h0C;
  localparam logic [4:0] REG_IRQ_MASK = 5'h10;
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_EMPTY_BIT = 3;
  localparam int STAT_DONE_BIT = 4;
  localparam int STAT_OK_BIT = 5;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int IRQ_DREQ_BIT = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [7:0] SYNC_BYTE_RESET = 8'h6A;

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    D_RESET = 3'h0, D_WAIT_ST = 3'h1, D_WAIT_CE = 3'h2, D_RECV = 3'h3,
    D_DONE_WAIT = 3'h4, D_INIT = 3'h5, D_USER = 3'h6, D_ERR = 3'h7
  } psc_dev_state_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_REQ = 3'h1, H_WAIT_ST = 3'h2, H_SHIFT = 3'h3,
    H_POST = 3'h4, H_DONE = 3'h5, H_ERR = 3'h6
  } psc_host_state_e;

endpackage : psc_pkg

/* common/psc_link_if.sv */
// link between the configuration host and one configured device
`timescale 1ns/10ps
interface psc_link_if;
  logic config_bit_clock;
  logic serial_config_data;
  logic config_request_n;
  logic chip_enable_in_n;
  logic chain_enable_out_n;
  logic user_startup_clock;
  logic status_drv;
  logic status_oe;
  logic complete_drv;
  logic complete_oe;
  wire config_status_n;
  wire config_complete;

  // open-drain lines with pull-up: low only while someone drives low
  assign config_status_n = ~(status_oe & ~status_drv);
  assign config_complete = ~(complete_oe & ~complete_drv);

  modport dev (
    input config_bit_clock, serial_config_data, config_request_n,
    input chip_enable_in_n, user_startup_clock,
    input config_status_n, config_complete,
    output chain_enable_out_n, status_drv, status_oe,
    output complete_drv, complete_oe
  );

  modport host (
    output config_bit_clock, serial_config_data, config_request_n,
    input config_status_n, config_complete
  );
endinterface : psc_link_if

/* rtl/psc_host.sv */
// host end: streams configuration bytes from software to the device
`timescale 1ns/10ps
module psc_host
  import psc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out,
  psc_link_if.host link
);

  // ----------------------------------------------------------------
  // synchronisers for status and complete
  // ----------------------------------------------------------------
  logic [1:0] s1_reg;
  logic [1:0] s2_reg;
  logic [1:0] s3_reg;
  logic [1:0] lvl_reg;
  logic [1:0] lvl_next;
  logic [1:0] settled;

  assign settled = ~(s2_reg ^ s3_reg);
  assign lvl_next = (settled & s3_reg) | (~settled & lvl_reg);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg <= {link.config_complete, link.config_status_n};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic wr_ctrl;
  logic wr_data;
  logic wr_mask;
  logic rd_irq;
  logic start;

  assign wr_ctrl = reg_wr_in && (reg_addr_in == REG_CTRL);
  assign wr_data = reg_wr_in && (reg_addr_in == REG_DATA);
  assign wr_mask = reg_wr_in && (reg_addr_in == REG_IRQ_MASK);
  assign rd_irq = reg_rd_in && (reg_addr_in == REG_IRQ_STATUS);
  assign start = wr_ctrl && reg_wdata_in[CTRL_START_BIT];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  psc_host_state_e state_reg;
  psc_host_state_e state_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [7:0] hold_reg;
  logic full_reg;
  logic [7:0] shift_reg;
  logic [3:0] bits_reg;
  logic clk_reg;
  logic sdat_reg;
  logic [1:0] falls_reg;
  logic [2:0] irq_reg;
  logic [2:0] mask_reg;
  logic [31:0] rdata_reg;

  logic half_end;
  logic load;
  logic rise;
  logic fall;
  logic [2:0] events;

  // half period never under half the device's minimum bit period
  assign half_end = (cnt_reg == BIT_HALF_CYC - 16'h1); // [R7]
  assign load = (state_reg == H_SHIFT) && (bits_reg == 4'h0) && full_reg
    && !clk_reg;
  assign rise = (state_reg == H_SHIFT) && half_end && !clk_reg
    && (bits_reg != 4'h0);
  assign fall = ((state_reg == H_SHIFT) || (state_reg == H_POST))
    && half_end && clk_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next = half_end ? 16'h0 : cnt_reg + 16'h1;
    unique case (state_reg)
      H_IDLE, H_DONE, H_ERR: begin
        cnt_next = '0;
      end
      H_REQ: begin
        cnt_next = cnt_reg + 16'h1;
        if (cnt_reg == T_CFG_CYC - 16'h1) begin
          state_next = H_WAIT_ST; // [R14]
          cnt_next = '0;
        end
      end
      H_WAIT_ST: begin
        cnt_next = lvl_reg[0] ? cnt_reg + 16'h1 : 16'h0;
        if (cnt_reg == T_ST2CK_CYC - 16'h1) begin
          state_next = H_SHIFT;
          cnt_next = '0;
        end
      end
      H_SHIFT: begin
        if (!lvl_reg[0]) begin
          state_next = H_ERR; // [R17]
        end else if (lvl_reg[1] && !clk_reg) begin
          state_next = H_POST; // [R15]
        end
      end
      H_POST: begin
        if (falls_reg == 2'(POST_FALL_EDGES)) begin
          state_next = H_DONE; // [R16]
        end
      end
      default: begin
        state_next = H_IDLE;
      end
    endcase
    if (start) begin
      state_next = H_REQ; // [R12]
      cnt_next = '0;
    end
  end

  assign events[IRQ_DONE_BIT] = (state_next == H_DONE)
    && (state_reg != H_DONE);
  assign events[IRQ_ERR_BIT] = (state_next == H_ERR)
    && (state_reg != H_ERR);
  assign events[IRQ_DREQ_BIT] = load;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= H_IDLE;
      cnt_reg <= '0;
      hold_reg <= '0;
      full_reg <= 1'b0;
      shift_reg <= '0;
      bits_reg <= '0;
      clk_reg <= 1'b0;
      sdat_reg <= 1'b0;
      falls_reg <= '0;
      irq_reg <= IRQ_RESET;
      mask_reg <= IRQ_RESET;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (wr_data) begin
        hold_reg <= reg_wdata_in[7:0];
      end
      full_reg <= wr_data || (full_reg && !load && !start);
      if (load) begin
        shift_reg <= hold_reg;
        bits_reg <= 4'h8;
        sdat_reg <= hold_reg[0]; // [R2]
      end else if (fall && state_reg == H_SHIFT) begin
        shift_reg <= {1'b0, shift_reg[7:1]};
        bits_reg <= bits_reg - 4'h1;
        sdat_reg <= shift_reg[1]; // [R2]
      end
      if (state_next == H_REQ) begin
        bits_reg <= '0;
      end
      if (rise || (state_reg == H_POST && half_end && !clk_reg)) begin
        clk_reg <= 1'b1;
      end else if (fall || state_next != state_reg) begin
        clk_reg <= 1'b0;
      end
      if (state_reg != H_POST) begin
        falls_reg <= '0;
      end else if (fall) begin
        falls_reg <= falls_reg + 2'h1;
      end
      // an event in the clearing cycle survives the read
      irq_reg <= (rd_irq ? 3'h0 : irq_reg) | events;
      if (wr_mask) begin
        mask_reg <= reg_wdata_in[2:0];
      end
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          REG_STATUS: rdata_reg <= {26'h0, lvl_reg[0], lvl_reg[1],
            ~full_reg, state_reg};
          REG_DATA: rdata_reg <= {24'h0, hold_reg};
          REG_IRQ_STATUS: rdata_reg <= {29'h0, irq_reg};
          REG_IRQ_MASK: rdata_reg <= {29'h0, mask_reg};
          default: rdata_reg <= '0;
        endcase
      end else begin
        rdata_reg <= '0;
      end
    end
  end

  assign link.config_bit_clock = clk_reg;
  assign link.serial_config_data = sdat_reg;
  assign link.config_request_n = (state_reg != H_REQ); // [R14]
  assign reg_rdata_out = rdata_reg;
  assign irq_out = |(irq_reg & mask_reg);

endmodule : psc_host

/* tb/psc_props.sv */
// concurrent checks on the configuration link between host and device
`timescale 1ns/10ps
module psc_props
  import psc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic config_bit_clock,
  input wire logic serial_config_data,
  input wire logic config_request_n,
  input wire logic chain_enable_out_n,
  input wire logic complete_oe,
  input wire logic config_status_n,
  input wire logic config_complete
);
  logic [15:0] req_lo_reg;
  logic [2:0] falls_reg;

  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  // falls are counted only while the shared complete line is high
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      req_lo_reg <= 16'h0;
      falls_reg <= 3'h0;
    end else begin
      req_lo_reg <= config_request_n ? 16'h0 : req_lo_reg + 16'h1;
      falls_reg <= !config_complete ? 3'h0 : falls_reg +
        {2'h0, $fell(config_bit_clock) && falls_reg != 3'h7};
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  // ------------------------------------------------------------
  // link properties
  // ------------------------------------------------------------
  property p_bit_high;
    $rose(config_bit_clock) |-> config_bit_clock [*4];
  endproperty
  a_bit_high: assert property (p_bit_high)
    else $error("bit clock high phase too short");

  property p_data_hold;
    config_bit_clock && $past(config_bit_clock) |->
      $stable(serial_config_data);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data moved while bit clock high");

  property p_req_width;
    $rose(config_request_n) |-> req_lo_reg >= T_CFG_CYC - 16'h2;
  endproperty
  a_req_width: assert property (p_req_width)
    else $error("request pulse too short");

  property p_quiet_in_req;
    !config_request_n |-> !config_bit_clock;
  endproperty
  a_quiet_in_req: assert property (p_quiet_in_req)
    else $error("bit clock high during request");

  property p_done_low;
    $fell(config_request_n) |-> ##[1:80] !config_complete;
  endproperty
  a_done_low: assert property (p_done_low)
    else $error("complete not pulled low after request");

  property p_chain_reset;
    $fell(config_request_n) |-> ##[1:8] chain_enable_out_n;
  endproperty
  a_chain_reset: assert property (p_chain_reset)
    else $error("chain enable not released on request");

  property p_chain_loaded;
    $fell(chain_enable_out_n) |-> ##[0:4] !complete_oe;
  endproperty
  a_chain_loaded: assert property (p_chain_loaded)
    else $error("chain enable low before load finished");

  property p_err_stop;
    $fell(config_status_n) && config_request_n |->
      ##[1:12] !config_bit_clock [*8];
  endproperty
  a_err_stop: assert property (p_err_stop)
    else $error("bit clock kept running after error");

  property p_two_falls;
    $rose(config_complete) |-> ##[1:60] falls_reg == 3'h2;
  endproperty
  a_two_falls: assert property (p_two_falls)
    else $error("wrong count of falls after complete");
endmodule : psc_props

/* tb/psc_tb_top.sv */
// testbench: host and device joined over the configuration link
`timescale 1ns/10ps
module psc_tb_top;
  import psc_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] reg_addr_in = 5'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic rd_want = 1'b0;
  logic chk_d = 1'b0;
  logic use_user_clock_in = 1'b0;
  logic uclk = 1'b0;
  logic uclk_en = 1'b0;
  logic [31:0] reg_rdata_out;
  logic irq_out;
  logic user_mode_out;
  logic config_error_out;
  logic config_byte_valid_out;
  logic [7:0] config_byte_out;
  logic [63:0] rq[$];
  logic [7:0] bq[$];
  logic [31:0] q;
  logic [7:0] b1;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int init_cnt = 0;

  psc_link_if link_i();
  // single device, so its enable is tied active
  assign link_i.chip_enable_in_n = 1'b0;
  assign link_i.user_startup_clock = uclk & uclk_en;

  psc_device #(.CFG_BITS(16), .INIT_OSC_COUNT(20), .INIT_USR_COUNT(8))
    psc_device_i (.clock_in(clock_in), .rst_in(rst_in), .link(link_i.dev),
    .use_user_clock_in(use_user_clock_in), .user_mode_out(user_mode_out),
    .config_error_out(config_error_out), .config_byte_out(config_byte_out),
    .config_byte_valid_out(config_byte_valid_out));
  psc_host psc_host_i (.clock_in(clock_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .irq_out(irq_out), .link(link_i.host));
  psc_props psc_props_i (.clock_in(clock_in), .rst_in(rst_in),
    .config_bit_clock(link_i.config_bit_clock),
    .serial_config_data(link_i.serial_config_data),
    .config_request_n(link_i.config_request_n),
    .chain_enable_out_n(link_i.chain_enable_out_n),
    .complete_oe(link_i.complete_oe),
    .config_status_n(link_i.config_status_n),
    .config_complete(link_i.config_complete));

  initial begin
    forever #5 clock_in = ~clock_in;
  end
  // user clock offset in phase from the system clock
  initial begin
    #3;
    forever #40 uclk = ~uclk;
  end

  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // init_cnt holds cycles from complete high to user mode
  always @(posedge clock_in) begin
    chk_d <= reg_rd_in & rd_want;
    cyc <= cyc + 1;
    init_cnt <= !link_i.config_complete ? 0 :
      init_cnt + (user_mode_out ? 0 : 1);
    if (chk_d && rq.size() > 0) begin
      chk(reg_rdata_out & rq[0][63:32], rq[0][31:0]);
      void'(rq.pop_front());
    end
    if (config_byte_valid_out && bq.size() > 0) begin
      chk({24'h0, config_byte_out}, {24'h0, bq.pop_front()});
    end
    if (cyc > 40000) begin
      n_fail++;
      finish_test();
    end
  end

  // ------------------------------------------------------------
  // register bus and sequences
  // ------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic w,
      input logic [31:0] m, input logic [31:0] e);
    @(posedge clock_in);
    if (w) rq.push_back({m, e});
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    rd_want <= w;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    @(posedge clock_in);
    q = reg_rdata_out;
  endtask : rd

  task automatic poll(input logic [31:0] m, input logic [31:0] e);
    int k = 0;
    do begin
      rd(REG_STATUS, 1'b0, 32'h0, 32'h0);
      k++;
    end while ((q & m) !== e && k < 2000);
    chk(q & m, e);
  endtask : poll

  // a bad first byte stalls the host, so the second is never sent
  task automatic cfg(input logic [7:0] b0, input logic [7:0] bb,
      input logic ok);
    bq.push_back(b0);
    if (ok) begin
      bq.push_back(bb);
    end
    wr(REG_CTRL, 32'h1);
    wr(REG_DATA, {24'h0, b0});
    poll(32'h8, 32'h8);
    if (ok) begin
      wr(REG_DATA, {24'h0, bb});
      poll(32'h7, 32'h5);
    end else begin
      poll(32'h7, 32'h6);
    end
  endtask : cfg

  task automatic wait_user();
    int k = 0;
    while (user_mode_out !== 1'b1 && k < 500) begin
      @(posedge clock_in);
      k++;
    end
    chk({31'h0, user_mode_out}, 32'h1);
    chk({31'h0, link_i.chain_enable_out_n}, 32'h0);
    chk({31'h0, bq.size() == 0}, 32'h1);
  endtask : wait_user

  initial begin
    void'($urandom(32'h40EECF9B));
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(REG_STATUS, 1'b1, 32'hF, 32'h8);
    rd(REG_IRQ_STATUS, 1'b1, 32'h7, {29'h0, IRQ_RESET});
    rd(REG_IRQ_MASK, 1'b1, 32'h7, {29'h0, IRQ_RESET});
    rd(5'h14, 1'b1, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, irq_out}, 32'h0);
    $display("test reset values done");
    wr(REG_IRQ_MASK, 32'h1);
    b1 = 8'($urandom());
    cfg(SYNC_BYTE_RESET, b1, 1'b1);
    wait_user();
    chk({31'h0, init_cnt >= 20 && init_cnt < 40}, 32'h1);
    rd(REG_STATUS, 1'b1, 32'h37, 32'h35);
    rd(REG_DATA, 1'b1, 32'hFF, {24'h0, b1});
    chk({31'h0, irq_out}, 32'h1);
    rd(REG_IRQ_STATUS, 1'b1, 32'h7, 32'h5);
    chk({31'h0, irq_out}, 32'h0);
    $display("test oscillator start-up done");
    use_user_clock_in <= 1'b1;
    uclk_en <= 1'b1;
    cfg(SYNC_BYTE_RESET, ~b1, 1'b1);
    wait_user();
    chk({31'h0, init_cnt >= 56 && init_cnt < 120}, 32'h1);
    rd(REG_IRQ_STATUS, 1'b1, 32'h7, 32'h5);
    $display("test user clock start-up done");
    uclk_en <= 1'b0;
    use_user_clock_in <= 1'b0;
    b1 = SYNC_BYTE_RESET ^ (8'($urandom()) | 8'h01);
    cfg(b1, 8'h00, 1'b0);
    chk({31'h0, config_error_out}, 32'h1);
    chk({31'h0, link_i.config_status_n}, 32'h0);
    rd(REG_STATUS, 1'b1, 32'h37, 32'h06);
    chk({31'h0, irq_out}, 32'h0);
    wr(REG_IRQ_MASK, 32'h3);
    @(posedge clock_in);
    chk({31'h0, irq_out}, 32'h1);
    rd(REG_IRQ_STATUS, 1'b1, 32'h2, 32'h2);
    chk({31'h0, irq_out}, 32'h0);
    $display("test bad sync byte done");
    cfg(SYNC_BYTE_RESET, b1, 1'b1);
    wait_user();
    chk({31'h0, config_error_out}, 32'h0);
    $display("test restart after error done");
    finish_test();
  end
endmodule : psc_tb_top
